// File: logic/aofd_consts.svh
// register offsets, field widths and timing counts for the detector
`ifndef AOFD_CONSTS_SVH
`define AOFD_CONSTS_SVH
`define AOFD_ADDR_W 12
`define AOFD_DATA_W 8
`define AOFD_SAMPLE_W 14
`define AOFD_MAG_W 13
`define AOFD_DWELL_W 16
`define AOFD_VCONV_N 8
`define AOFD_OFS_UPPER_LO 12'h247
`define AOFD_OFS_UPPER_HI 12'h248
`define AOFD_OFS_LOWER_LO 12'h249
`define AOFD_OFS_LOWER_HI 12'h24a
`define AOFD_OFS_DWELL_LO 12'h24b
`define AOFD_OFS_DWELL_HI 12'h24c
`define AOFD_OFS_OVR_CLEAR 12'h562
`define AOFD_OFS_OVR_STICKY 12'h563
`define AOFD_RST_UPPER 13'h1fff
`define AOFD_RST_LOWER 13'h0000
`define AOFD_RST_DWELL 16'h0001
// upper detect latency bound, in sample clocks
`define AOFD_UPPER_LAT_MAX 28
// sample pipeline latency modelled for the overrange indicator
`define AOFD_PIPE_LAT 4
`endif

// File: logic/aofd_pkg.sv
// shared types for the overrange and fast detect block
package aofd_pkg;
  // state of one fast detect channel
  typedef enum logic [1:0] {AOFD_IDLE, AOFD_HELD, AOFD_DWELL} aofd_state_t;
endpackage

// File: logic/aofd_channel.sv
// one channel of fast threshold detection with dwell hysteresis
`timescale 1ns/1ps
`include "aofd_consts.svh"
module aofd_channel
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // sample magnitude and thresholds
  input wire logic [`AOFD_MAG_W-1:0] mag,
  input wire logic [`AOFD_MAG_W-1:0] upper_thr,
  input wire logic [`AOFD_MAG_W-1:0] lower_thr,
  input wire logic [`AOFD_DWELL_W-1:0] dwell,
  // detect flag, registered
  output logic threshold_flag
);
  import aofd_pkg::*;

  aofd_state_t state_r, state_nxt; // detector state
  logic [`AOFD_DWELL_W-1:0] cnt_r, cnt_nxt; // cycles spent below lower
  logic flag_nxt; // next flag value

  // next state: set on upper crossing, release after dwell
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    flag_nxt = threshold_flag;
    if (mag > upper_thr)
    begin
      // crossing sets the flag in the next cycle
      state_nxt = AOFD_HELD;
      flag_nxt = 1'b1;
      cnt_nxt = '0;
    end
    else
    begin
      unique case (state_r)
        AOFD_IDLE:
        begin
          flag_nxt = 1'b0;
        end
        AOFD_HELD:
        begin
          // start dwell once magnitude drops below lower
          if (mag < lower_thr)
          begin
            state_nxt = AOFD_DWELL;
            cnt_nxt = 16'h0001;
          end
        end
        AOFD_DWELL:
        begin
          if (mag >= lower_thr)
          begin
            // rose back before dwell elapsed: restart
            state_nxt = AOFD_HELD;
            cnt_nxt = '0;
          end
          else if (cnt_r >= dwell)
          begin
            // below lower for more than dwell cycles: release
            state_nxt = AOFD_IDLE;
            flag_nxt = 1'b0;
            cnt_nxt = '0;
          end
          else
          begin
            // one more cycle below lower, bounded by dwell
            cnt_nxt = cnt_r + 16'h0001;
          end
        end
      endcase
    end
  end

  // register state, count and flag
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_r <= AOFD_IDLE;
      cnt_r <= '0;
      threshold_flag <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      threshold_flag <= flag_nxt;
    end
  end
endmodule

// File: logic/aofd_top.sv
// overrange and fast detect block for a dual converter
`timescale 1ns/1ps
`include "aofd_consts.svh"
module aofd_top
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // converter samples, two's complement, one per clock per channel
  input wire logic [`AOFD_SAMPLE_W-1:0] sample_a,
  input wire logic [`AOFD_SAMPLE_W-1:0] sample_b,
  // raw overrange from each converter input
  input wire logic ovr_in_a,
  input wire logic ovr_in_b,
  // overrange per virtual converter, from the mapping logic
  input wire logic [`AOFD_VCONV_N-1:0] vconv_ovr,
  // number of control bits per sample on the link
  input wire logic [1:0] ctrl_bits_cfg,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`AOFD_ADDR_W-1:0] reg_addr,
  input wire logic [`AOFD_DATA_W-1:0] reg_wdata,
  output logic [`AOFD_DATA_W-1:0] reg_rdata,
  // delayed samples with overrange, toward the serial link
  output logic [`AOFD_SAMPLE_W-1:0] link_sample_a,
  output logic [`AOFD_SAMPLE_W-1:0] link_sample_b,
  output logic link_ctrl_a,
  output logic link_ctrl_b,
  output logic ovr_out_a,
  output logic ovr_out_b,
  // fast detect pins
  output logic threshold_flag_pin_first,
  output logic threshold_flag_pin_second
);
  import aofd_pkg::*;

  localparam int LAT = `AOFD_PIPE_LAT;

  logic [15:0] upper_r, upper_nxt; // upper threshold pair
  logic [15:0] lower_r, lower_nxt; // lower threshold pair
  logic [15:0] dwell_r, dwell_nxt; // dwell time pair
  logic [7:0] clear_r, clear_nxt; // clear register
  logic [7:0] sticky_r, sticky_nxt; // sticky overrange bits
  logic [7:0] rdata_nxt; // read data next value
  logic [12:0] upper_thr; // 13-bit upper magnitude
  logic [12:0] lower_thr; // 13-bit lower magnitude
  logic [15:0] dwell_eff; // dwell, zero treated as one
  logic [12:0] mag_a_r, mag_b_r, mag_a_nxt, mag_b_nxt; // magnitudes
  logic [LAT-1:0][13:0] pipe_a_r, pipe_b_r, pipe_a_nxt, pipe_b_nxt;
  logic [LAT-1:0] ovp_a_r, ovp_b_r, ovp_a_nxt, ovp_b_nxt; // ovr pipe
  logic [13:0] lsa_nxt, lsb_nxt; // link sample next
  logic lca_nxt, lcb_nxt, ooa_nxt, oob_nxt; // link control next
  logic flag_a, flag_b; // registered channel flags
  logic pin_a_nxt, pin_b_nxt; // pin next values

  // magnitude of a 14-bit two's complement sample, saturated to 13 bits
  function automatic logic [12:0] mag_of(input logic [13:0] s);
    logic [13:0] n;
    n = s[13] ? (~s + 14'h0001) : s;
    mag_of = n[13] ? 13'h1fff : n[12:0];
  endfunction

  assign upper_thr = upper_r[12:0];
  assign lower_thr = lower_r[12:0];
  // zero is outside the legal range, treated as one cycle
  assign dwell_eff = (dwell_r == 16'h0000) ? 16'h0001 : dwell_r;

  // register writes, clears and reads
  always_comb
  begin
    upper_nxt = upper_r;
    lower_nxt = lower_r;
    dwell_nxt = dwell_r;
    clear_nxt = clear_r;
    rdata_nxt = reg_rdata;
    if (reg_wr)
    begin
      unique case (reg_addr)
        `AOFD_OFS_UPPER_LO: upper_nxt[7:0] = reg_wdata;
        `AOFD_OFS_UPPER_HI: upper_nxt[15:8] = {3'h0, reg_wdata[4:0]};
        `AOFD_OFS_LOWER_LO: lower_nxt[7:0] = reg_wdata;
        `AOFD_OFS_LOWER_HI: lower_nxt[15:8] = {3'h0, reg_wdata[4:0]};
        `AOFD_OFS_DWELL_LO: dwell_nxt[7:0] = reg_wdata;
        `AOFD_OFS_DWELL_HI: dwell_nxt[15:8] = reg_wdata;
        `AOFD_OFS_OVR_CLEAR: clear_nxt = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd)
    begin
      unique case (reg_addr)
        `AOFD_OFS_UPPER_LO: rdata_nxt = upper_r[7:0];
        `AOFD_OFS_UPPER_HI: rdata_nxt = upper_r[15:8];
        `AOFD_OFS_LOWER_LO: rdata_nxt = lower_r[7:0];
        `AOFD_OFS_LOWER_HI: rdata_nxt = lower_r[15:8];
        `AOFD_OFS_DWELL_LO: rdata_nxt = dwell_r[7:0];
        `AOFD_OFS_DWELL_HI: rdata_nxt = dwell_r[15:8];
        `AOFD_OFS_OVR_CLEAR: rdata_nxt = clear_r;
        `AOFD_OFS_OVR_STICKY: rdata_nxt = sticky_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // sticky bits: cleared while clear bit is one, but a set in the same cycle always wins
  always_comb
  begin
    sticky_nxt = (sticky_r & ~clear_r) | vconv_ovr;
  end

  // register file and sticky status
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      upper_r <= {3'h0, `AOFD_RST_UPPER};
      lower_r <= {3'h0, `AOFD_RST_LOWER};
      dwell_r <= `AOFD_RST_DWELL;
      clear_r <= 8'h00;
      sticky_r <= 8'h00;
      reg_rdata <= 8'h00;
    end
    else
    begin
      upper_r <= upper_nxt;
      lower_r <= lower_nxt;
      dwell_r <= dwell_nxt;
      clear_r <= clear_nxt;
      sticky_r <= sticky_nxt;
      reg_rdata <= rdata_nxt;
    end
  end

  // magnitude taken at converter output, sample and overrange pipes
  always_comb
  begin
    mag_a_nxt = mag_of(sample_a);
    mag_b_nxt = mag_of(sample_b);
    pipe_a_nxt = {pipe_a_r[LAT-2:0], sample_a};
    pipe_b_nxt = {pipe_b_r[LAT-2:0], sample_b};
    // overrange travels in step with its sample
    ovp_a_nxt = {ovp_a_r[LAT-2:0], ovr_in_a};
    ovp_b_nxt = {ovp_b_r[LAT-2:0], ovr_in_b};
    lsa_nxt = pipe_a_r[LAT-1];
    lsb_nxt = pipe_b_r[LAT-1];
    ooa_nxt = ovp_a_r[LAT-1];
    oob_nxt = ovp_b_r[LAT-1];
    // control bit carries overrange only when configured
    lca_nxt = (ctrl_bits_cfg != 2'h0) && ovp_a_r[LAT-1];
    lcb_nxt = (ctrl_bits_cfg != 2'h0) && ovp_b_r[LAT-1];
    pin_a_nxt = flag_a;
    pin_b_nxt = flag_b;
  end

  // register datapath and pins
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mag_a_r <= '0;
      mag_b_r <= '0;
      pipe_a_r <= '0;
      pipe_b_r <= '0;
      ovp_a_r <= '0;
      ovp_b_r <= '0;
      link_sample_a <= '0;
      link_sample_b <= '0;
      link_ctrl_a <= 1'b0;
      link_ctrl_b <= 1'b0;
      ovr_out_a <= 1'b0;
      ovr_out_b <= 1'b0;
      threshold_flag_pin_first <= 1'b0;
      threshold_flag_pin_second <= 1'b0;
    end
    else
    begin
      mag_a_r <= mag_a_nxt;
      mag_b_r <= mag_b_nxt;
      pipe_a_r <= pipe_a_nxt;
      pipe_b_r <= pipe_b_nxt;
      ovp_a_r <= ovp_a_nxt;
      ovp_b_r <= ovp_b_nxt;
      link_sample_a <= lsa_nxt;
      link_sample_b <= lsb_nxt;
      link_ctrl_a <= lca_nxt;
      link_ctrl_b <= lcb_nxt;
      ovr_out_a <= ooa_nxt;
      ovr_out_b <= oob_nxt;
      // pin is three cycles after the sample, well inside bound
      threshold_flag_pin_first <= pin_a_nxt;
      threshold_flag_pin_second <= pin_b_nxt;
    end
  end

  // independent detector per channel
  aofd_channel u_chan_a
  (
    .clk(clk),
    .srst(srst),
    .mag(mag_a_r),
    .upper_thr(upper_thr),
    .lower_thr(lower_thr),
    .dwell(dwell_eff),
    .threshold_flag(flag_a)
  );

  aofd_channel u_chan_b
  (
    .clk(clk),
    .srst(srst),
    .mag(mag_b_r),
    .upper_thr(upper_thr),
    .lower_thr(lower_thr),
    .dwell(dwell_eff),
    .threshold_flag(flag_b)
  );
endmodule

// File: dv/aofd_top_monitor.sv
// checker for the overrange and fast detect block
`timescale 1ns/1ps
module aofd_top_monitor
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // samples and register port
  input wire logic [13:0] sample_a,
  input wire logic [13:0] sample_b,
  input wire logic ovr_in_a,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  // outputs
  input wire logic [7:0] reg_rdata,
  input wire logic [13:0] link_sample_a,
  input wire logic [13:0] link_sample_b,
  input wire logic ovr_out_a,
  input wire logic link_ctrl_a,
  input wire logic threshold_flag_pin_first
);
  logic [12:0] up_r, lo_r, mag; // shadow levels, channel a size
  logic [15:0] dw_r, run_r; // shadow dwell, run of low samples
  logic [2:0] age_r; // cycles since reset, saturating
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // magnitude, full negative scale saturates
  assign mag = (sample_a == 14'h2000) ? 13'h1fff :
    sample_a[13] ? 13'(-sample_a) : sample_a[12:0];
  // shadow registers follow the writes
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      up_r <= 13'h1fff;
      lo_r <= 13'h0000;
      dw_r <= 16'h0001;
      run_r <= 16'h0000;
      age_r <= 3'h0;
    end
    else
    begin
      age_r <= (age_r == 3'h7) ? age_r : age_r + 3'h1;
      run_r <= (mag < lo_r) ? run_r + 16'h0001 : 16'h0000;
      if (reg_wr)
      begin
        case (reg_addr)
          12'h247: up_r[7:0] <= reg_wdata;
          12'h248: up_r[12:8] <= reg_wdata[4:0];
          12'h249: lo_r[7:0] <= reg_wdata;
          12'h24a: lo_r[12:8] <= reg_wdata[4:0];
          12'h24b: dw_r[7:0] <= reg_wdata;
          12'h24c: dw_r[15:8] <= reg_wdata;
          default: ;
        endcase
      end
    end
  end
  // a crossing and the pin that answers it
  sequence s_cross;
    mag > up_r;
  endsequence
  sequence s_pin_up;
    ##[3:4] threshold_flag_pin_first;
  endsequence
  a_link_a_delay:
    assert property (age_r == 3'h7 |-> link_sample_a == $past(sample_a, 5))
    else $error("channel a sample not five cycles late");
  a_link_b_delay:
    assert property (age_r == 3'h7 |-> link_sample_b == $past(sample_b, 5))
    else $error("channel b sample not five cycles late");
  a_ovr_follows_sample:
    assert property (age_r == 3'h7 |-> ovr_out_a == $past(ovr_in_a, 5))
    else $error("overrange a not aligned with its sample");
  a_ctrl_needs_ovr:
    assert property (link_ctrl_a |-> ovr_out_a)
    else $error("control bit without overrange");
  a_upper_sets_flag:
    assert property (s_cross |-> s_pin_up)
    else $error("pin a late after upper crossing");
  a_dwell_release:
    assert property ($fell(threshold_flag_pin_first) |->
      $past(run_r, 2) > ((dw_r == 16'h0000) ? 16'h0001 : dw_r))
    else $error("pin a released before dwell ran out");
  a_lower_hi_read:
    assert property (reg_rd && reg_addr == 12'h24a |=>
      reg_rdata == {3'h0, lo_r[12:8]})
    else $error("lower level high byte reads wrong");
  a_dwell_hi_read:
    assert property (reg_rd && reg_addr == 12'h24c |=> reg_rdata == dw_r[15:8])
    else $error("dwell high byte reads wrong");
endmodule
bind aofd_top aofd_top_monitor u_aofd_top_monitor
(
  .clk(clk), .srst(srst), .sample_a(sample_a), .sample_b(sample_b),
  .ovr_in_a(ovr_in_a), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .link_sample_a(link_sample_a), .link_sample_b(link_sample_b),
  .ovr_out_a(ovr_out_a), .link_ctrl_a(link_ctrl_a),
  .threshold_flag_pin_first(threshold_flag_pin_first)
);

// File: dv/aofd_agc_model.sv
// gain control model that reacts to the fast detect pins
`timescale 1ns/1ps
module aofd_agc_model
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // fast detect pins
  input wire logic flag_a,
  input wire logic flag_b,
  // gain cuts taken per channel
  output logic [7:0] cuts_a,
  output logic [7:0] cuts_b
);
  logic pa_r, pb_r; // pin levels one cycle back
  // one gain cut per rising pin
  always_ff @(posedge clk)
  begin
    pa_r <= srst ? 1'b0 : flag_a;
    pb_r <= srst ? 1'b0 : flag_b;
    cuts_a <= srst ? 8'h00 : cuts_a + 8'(flag_a & ~pa_r);
    cuts_b <= srst ? 8'h00 : cuts_b + 8'(flag_b & ~pb_r);
  end
endmodule

// File: dv/aofd_top_tb_top.sv
// self-checking bench for the overrange and fast detect block
`timescale 1ns/1ps
module aofd_top_tb_top;
  logic clk = 1'b0; // sample clock
  logic srst = 1'b1; // sync reset
  logic [13:0] sa = 14'h0, sb = 14'h0, lsa, lsb; // samples
  logic oa = 1'b0, ob = 1'b0, ooa, oob, lca, lcb; // overrange bits
  logic [7:0] vconv_ovr = 8'h00; // virtual converter overrange
  logic [1:0] ctrl_bits_cfg = 2'h0; // control bits per sample
  logic reg_wr = 1'b0, reg_rd = 1'b0; // register strobes
  logic [11:0] reg_addr = 12'h0; // register offset
  logic [7:0] reg_wdata = 8'h0, reg_rdata, cuts_a, cuts_b; // data
  logic fa, fb; // fast detect pins
  int error_cnt = 0, checked = 0, cyc = 0; // counters
  always #2.5 clk = ~clk;
  aofd_top u_aofd_top (.clk(clk), .srst(srst), .sample_a(sa),
    .sample_b(sb), .ovr_in_a(oa), .ovr_in_b(ob), .vconv_ovr(vconv_ovr),
    .ctrl_bits_cfg(ctrl_bits_cfg), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .link_sample_a(lsa), .link_sample_b(lsb), .link_ctrl_a(lca),
    .link_ctrl_b(lcb), .ovr_out_a(ooa), .ovr_out_b(oob),
    .threshold_flag_pin_first(fa), .threshold_flag_pin_second(fb));
  aofd_agc_model u_aofd_agc_model (.clk(clk), .srst(srst), .flag_a(fa),
    .flag_b(fb), .cuts_a(cuts_a), .cuts_b(cuts_b));
  // compare and count
  task automatic chk(input string w, input logic [15:0] s, e);
    checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", w, e, s);
    end
  endtask
  // register write, strobe for one edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  // register read, data holds so look two edges late
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    repeat (2) @(posedge clk);
    chk("rdata", 16'(reg_rdata), 16'(e));
  endtask
  // n cycles of fixed samples
  task automatic drv(input logic [13:0] a, b, input logic o, input int n);
    repeat (n)
    begin
      sa <= a;
      sb <= b;
      oa <= o;
      ob <= o;
      @(posedge clk);
    end
  endtask
  task automatic t_regs;
    rd(12'h248, 8'h1f);
    rd(12'h24b, 8'h01);
    wr(12'h24c, 8'hff);
    rd(12'h24c, 8'hff);
    wr(12'h24a, 8'hff);
    rd(12'h24a, 8'h1f);
    rd(12'h123, 8'h00); // unmapped reads zero
    $display("register test done");
  endtask
  // upper 100, lower 50, dwell 2
  task automatic t_detect;
    wr(12'h247, 8'h64);
    wr(12'h248, 8'h00);
    wr(12'h249, 8'h32);
    wr(12'h24a, 8'h00);
    wr(12'h24b, 8'h02);
    wr(12'h24c, 8'h00);
    drv(14'h3f38, 14'h0, 1'b0, 1);
    drv(14'h0046, 14'h0, 1'b0, 5);
    chk("pin a", 16'(fa), 16'h1);
    chk("pin b", 16'(fb), 16'h0);
    drv(14'h000a, 14'h0, 1'b0, 2);
    drv(14'h0046, 14'h0, 1'b0, 1);
    drv(14'h000a, 14'h0, 1'b0, 3);
    chk("pin held", 16'(fa), 16'h1);
    drv(14'h000a, 14'h0, 1'b0, 5);
    chk("pin freed", 16'(fa), 16'h0);
    chk("cuts a", 16'(cuts_a), 16'h1);
    drv(14'h0, 14'h2000, 1'b0, 1);
    // look before the dwell release launches a new pin level
    drv(14'h0, 14'h0, 1'b0, 4);
    chk("pin b", 16'(fb), 16'h1);
    chk("cuts b", 16'(cuts_b), 16'h1);
    chk("pin a", 16'(fa), 16'h0);
    $display("detect test done");
  endtask
  // every control bit setting
  task automatic t_link;
    for (int c = 0; c < 4; c++)
    begin
      ctrl_bits_cfg <= 2'(c);
      drv(14'h1234, 14'h2bcd, 1'b1, 2);
      // first sample is still on the link at this edge
      drv(14'h0, 14'h0, 1'b0, 4);
      chk("link a", 16'(lsa), 16'h1234);
      chk("link b", 16'(lsb), 16'h2bcd);
      chk("ovr a", 16'(ooa), 16'h1);
      chk("ovr b", 16'(oob), 16'h1);
      chk("ctrl a", 16'(lca), 16'(c != 0));
      chk("ctrl b", 16'(lcb), 16'(c != 0));
    end
    $display("link test done");
  endtask
  task automatic t_sticky;
    vconv_ovr <= 8'h05;
    @(posedge clk);
    vconv_ovr <= 8'h00;
    wr(12'h563, 8'hff);
    rd(12'h563, 8'h05);
    wr(12'h562, 8'h01);
    wr(12'h562, 8'h00);
    rd(12'h563, 8'h04);
    $display("sticky test done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      error_cnt++;
      tally_and_finish;
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    t_regs;
    t_detect;
    t_link;
    t_sticky;
    tally_and_finish;
  end
endmodule
